// ### src/mac_slave.v
/*
 * Slave end of the serial link MAC handshake, with a mode 0 byte shifter.
 * Assumes: all link pins come from another clock domain and are sampled by
 * clk; the pad logic resolves the open-drain select line from its enable;
 * the user side lives on clk.
 */
// Overview of operation
// - Report ready time covering pulse width and internal latencies.
// - Every request pulse stays asserted at least one microsecond.
// - Resume time runs from waking select to transfer; slave reports it.
// - Five-wire slave requests only after sampling select high.
// - After a request, slave prepares and waits for master access.
// - On simultaneous five-wire start, slave still requests and then is selected.
// - With supply invalid, slave leaves all link lines undriven.
// - Four-wire slave disables its serial module before driving select.
// - Slave leaves request state by itself after the pulse width.
// - Until accessed after a request, slave stays deselected.
`timescale 1ns/1ps
`include "mac_handshake_regs.vh"

module mac_slave (
    // System
    input wire clk,
    input wire rstn,
    // Link pins
    input wire sel_n_in,
    input wire link_clk,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    output reg req_int,
    output reg sel_drv,
    output reg sel_drv_oe,
    // Supply and mode
    input wire supply_ok,
    input wire four_wire,
    input wire power_saving,
    // User side
    input wire service_req,
    input wire [7:0] tx_byte,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    output reg req_done,
    output reg selected,
    output reg module_en,
    output reg asleep,
    output reg [7:0] readiness_report_msg_ready,
    output reg [7:0] readiness_report_msg_resume
);

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
wire [3:0] raw_in = {supply_ok, mosi, link_clk, sel_n_in};
reg [3:0] sync1;
reg [3:0] sync2;
reg clk_d;
// Reset each stage to its pin's idle level: select high, link clock and data
// low, supply good; a link clock reset high would fake an edge after reset
localparam [3:0] sync_rst = 4'h9;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
        // Two flops per pin; only the second is read by logic
        always @(posedge clk) begin
            if (!rstn) begin
                sync1[g] <= sync_rst[g];
                sync2[g] <= sync_rst[g];
            end else begin
                sync1[g] <= raw_in[g];
                sync2[g] <= sync1[g];
            end
        end
    end
endgenerate

wire sel_hi = sync2[0];
wire sclk = sync2[1];
wire mosi_s = sync2[2];
wire pwr_s = sync2[3];
wire sclk_rise = sclk & ~clk_d;
wire sclk_fall = ~sclk & clk_d;

// ----------------------------------------------------------------------
// Handshake state machine and byte shifter
// ----------------------------------------------------------------------
reg [`ST_W-1:0] state;
reg [`CNT_W-1:0] cnt;
reg [7:0] tx_sh;
reg [7:0] rx_sh;
reg [2:0] bit_cnt;
reg seen_high;

// One-hot state codes
localparam [`ST_W-1:0] st_idle = `ST_IDLE;
localparam [`ST_W-1:0] st_disable = `ST_DISABLE;
localparam [`ST_W-1:0] st_req = `ST_REQ;
localparam [`ST_W-1:0] st_wait = `ST_WAIT;
localparam [`ST_W-1:0] st_sel = `ST_SEL;
// Counter loads; only the low bits reach the counter, cut on purpose
localparam [31:0] pulse_load = `REQ_PULSE_CYC - 1;
localparam [31:0] wait_load = `SETTLE_CYC + `PREP_CYC;
localparam [31:0] prep_lim = `PREP_CYC;

always @(posedge clk) begin
    if (!rstn) begin
        state <= st_idle;
        cnt <= 8'h00;
        clk_d <= 1'b0;
        tx_sh <= 8'h00;
        rx_sh <= 8'h00;
        bit_cnt <= 3'h0;
        seen_high <= 1'b0;
        miso <= 1'b0;
        miso_oe <= 1'b0;
        req_int <= 1'b0;
        sel_drv <= 1'b0;
        sel_drv_oe <= 1'b0;
        rx_byte <= 8'h00;
        rx_valid <= 1'b0;
        req_done <= 1'b0;
        selected <= 1'b0;
        module_en <= 1'b0;
        asleep <= 1'b0;
        readiness_report_msg_ready <= 8'h00;
        readiness_report_msg_resume <= 8'h00;
    end else begin
        clk_d <= sclk;
        rx_valid <= 1'b0;
        req_done <= 1'b0;
        asleep <= power_saving;
        // Reported times reach the message builder once out of reset
        readiness_report_msg_ready <= `READY_TIME_US;
        readiness_report_msg_resume <= `RESUME_TIME_US;
        if (!pwr_s) begin
            // Supply invalid: release every line we could drive
            state <= st_idle;
            miso_oe <= 1'b0;
            req_int <= 1'b0;
            sel_drv_oe <= 1'b0;
            module_en <= 1'b0;
            selected <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    module_en <= 1'b1;
                    if (!sel_hi && module_en) begin
                        // Master access; first bit valid at select
                        state <= st_sel;
                        selected <= 1'b1;
                        miso_oe <= 1'b1;
                        miso <= tx_byte[7];
                        tx_sh <= {tx_byte[6:0], 1'b0};
                        bit_cnt <= 3'h0;
                    end else if (service_req && sel_hi) begin
                        if (four_wire) begin
                            // Drop the module first so we never select ourselves
                            module_en <= 1'b0;
                            state <= st_disable;
                        end else begin
                            req_int <= 1'b1;
                            cnt <= pulse_load[`CNT_W-1:0];
                            state <= st_req;
                        end
                    end
                end
                st_disable: begin
                    // Module now off; drive the shared select low
                    sel_drv <= 1'b0;
                    sel_drv_oe <= 1'b1;
                    cnt <= pulse_load[`CNT_W-1:0];
                    state <= st_req;
                end
                st_req: begin
                    // Master inputs are ignored here; the pulse ends on its own
                    if (cnt == 8'h00) begin
                        req_int <= 1'b0;
                        sel_drv_oe <= 1'b0;
                        req_done <= 1'b1;
                        seen_high <= 1'b0;
                        cnt <= wait_load[`CNT_W-1:0];
                        state <= st_wait;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                st_wait: begin
                    // Re-enable within the ready time, stay deselected until
                    // the master selects
                    miso_oe <= 1'b0;
                    if (cnt != 8'h00)
                        cnt <= cnt - 8'h01;
                    else
                        module_en <= 1'b1;
                    if (sel_hi)
                        seen_high <= 1'b1;
                    // Five-wire select seen low right after the pulse means a
                    // simultaneous master start
                    if (!sel_hi && (!four_wire || seen_high) && cnt <= prep_lim[`CNT_W-1:0]) begin
                        module_en <= 1'b1;
                        state <= st_sel;
                        selected <= 1'b1;
                        miso_oe <= 1'b1;
                        miso <= tx_byte[7];
                        tx_sh <= {tx_byte[6:0], 1'b0};
                        bit_cnt <= 3'h0;
                    end
                end
                st_sel: begin
                    if (sel_hi) begin
                        // Master released select after the clock stopped
                        state <= st_idle;
                        selected <= 1'b0;
                        miso_oe <= 1'b0;
                    end else begin
                        // Mode 0: sample on rise, shift out on fall
                        if (sclk_rise) begin
                            rx_sh <= {rx_sh[6:0], mosi_s};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                rx_byte <= {rx_sh[6:0], mosi_s};
                                rx_valid <= 1'b1;
                                tx_sh <= tx_byte;
                            end
                        end
                        if (sclk_fall) begin
                            miso <= tx_sh[7];
                            tx_sh <= {tx_sh[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end
end

endmodule

// ### src/mac_handshake_regs.vh
/*
 * Constants for the slave-side MAC handshake: link timing, state codes and
 * the values carried in the readiness report message.
 * Assumes a system clock of 125 MHz; all waits are counted in that clock.
 */
`ifndef MAC_HANDSHAKE_REGS_VH
`define MAC_HANDSHAKE_REGS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
// Least request pulse width, in ns
`define REQ_PULSE_NS 1000
// Least pulse width in cycles, rounded up so the pulse never falls short
`define REQ_PULSE_CYC ((`REQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Internal latency to re-enable the serial module after a request, in ns
`define PREP_NS 200
`define PREP_CYC ((`PREP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Cycles the sense path needs to forget our own select drive
`define SETTLE_CYC 4
`define CNT_W 8

// ----------------------------------------------------------------------
// Readiness report contents, in whole microseconds
// ----------------------------------------------------------------------
// Ready time: pulse width + preparation + synchroniser lag, rounded up
`define READY_TIME_US 8'h02
// Resume time from power saving
`define RESUME_TIME_US 8'h0A

// ----------------------------------------------------------------------
// One-hot state codes
// ----------------------------------------------------------------------
`define ST_W 5
`define ST_IDLE 5'h01
`define ST_DISABLE 5'h02
`define ST_REQ 5'h04
`define ST_WAIT 5'h08
`define ST_SEL 5'h10

`endif

// ### testbench/mac_slave_asserts.sv
/* Checker for the slave MAC handshake pins.
   Assumes one clk domain and the synchronous active-low reset. */
`timescale 1ns/1ps
module mac_slave_chk (
    // System
    input wire clk,
    input wire rstn,
    // Link and status
    input wire sel_n_in,
    input wire supply_ok,
    input wire miso_oe,
    input wire req_int,
    input wire sel_drv_oe,
    input wire req_done,
    input wire selected,
    input wire module_en,
    input wire [7:0] readiness_report_msg_ready,
    input wire [7:0] readiness_report_msg_resume
);
    reg [7:0] plen;
    // Width of the request pulse on either request line
    always @(posedge clk) begin
        if (!rstn || !(req_int || sel_drv_oe))
            plen <= 8'h00;
        else
            plen <= plen + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_req_end;
        $fell(req_int) || $fell(sel_drv_oe);
    endsequence
    sequence s_reenable;
        !module_en [*8] ##[1:40] module_en;
    endsequence
    a_pulse_width: assert property (s_req_end |-> plen == 8'h7D && req_done)
        else $error("request pulse width wrong");
    a_pulse_ends: assert property (plen <= 8'h7D)
        else $error("request pulse overran");
    a_unpowered_quiet: assert property (!supply_ok [*5] |-> !miso_oe && !sel_drv_oe && !req_int)
        else $error("line driven without supply");
    a_disable_first: assert property ($rose(sel_drv_oe) |-> !module_en && $past(!module_en))
        else $error("select driven with module enabled");
    a_module_back: assert property ($fell(sel_drv_oe) |-> s_reenable)
        else $error("module not re-enabled");
    a_req_when_high: assert property ($rose(req_int) |-> $past(sel_n_in, 3))
        else $error("request while select low");
    a_quiet_request: assert property ((req_int || sel_drv_oe) |-> !miso_oe && !selected)
        else $error("selected during request");
    a_release_miso: assert property (sel_n_in [*6] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_report_values: assert property (
        $past(rstn, 3) && $past(rstn, 2) && $past(rstn)
        |-> readiness_report_msg_ready == 8'h02 && readiness_report_msg_resume == 8'h0A)
        else $error("readiness report wrong");
    // Selection is decided on the select level three samples back (two sync flops)
    a_sel_on_access: assert property ($rose(selected) |-> $past(sel_n_in, 3) == 1'b0)
        else $error("selected without select");
endmodule
bind mac_slave mac_slave_chk i_chk (.clk(clk), .rstn(rstn), .sel_n_in(sel_n_in),
    .supply_ok(supply_ok), .miso_oe(miso_oe), .req_int(req_int), .sel_drv_oe(sel_drv_oe),
    .req_done(req_done), .selected(selected), .module_en(module_en),
    .readiness_report_msg_ready(readiness_report_msg_ready),
    .readiness_report_msg_resume(readiness_report_msg_resume));

// ### testbench/host_master.sv
/* Host controller model: select, link clock at 160 ns, mode 0 data.
   Assumes the bench resolves the shared select line into sel_sense. */
`timescale 1ns/1ps
module host_master (
    // Link pins
    output reg sel_m_n,
    output reg sck,
    output reg mosi,
    input wire miso,
    input wire sel_sense
);
    // Select released before supply changes, clock idle low
    initial begin
        sel_m_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // One byte each way; the caller picks ready, longer or resume wait
    task automatic xfer(input int wait_ns, input logic [7:0] tx, output logic [7:0] rx);
        while (!sel_sense) #8;
        #3 sel_m_n = 1'b0;
        #(wait_ns);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #80 sck = 1'b1;
            rx[i] = miso;
            #80 sck = 1'b0;
        end
        #80 sel_m_n = 1'b1; // Only after the clock stops
        mosi = ~mosi; // A released line must not keep its last bit
        // Inactive gap: a select high for only a few ns slips past the sync flops
        #80;
    endtask
endmodule

// ### testbench/mac_slave_tb.sv
/* Self-checking bench for the slave MAC handshake.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
`include "mac_handshake_regs.vh"
module mac_slave_tb;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg supply_ok = 1'b1;
    reg four_wire = 1'b0;
    reg power_saving = 1'b0;
    reg service_req = 1'b0;
    reg [7:0] tx_byte = 8'h00;
    wire sel_m_n, sck, mosi, miso, miso_oe, req_int, sel_drv, sel_drv_oe;
    wire rx_valid, req_done, selected, module_en, asleep;
    wire [7:0] rx_byte, rpt_ready, rpt_resume;
    wire sel_line = sel_m_n & ~(sel_drv_oe & ~sel_drv);
    int n_mismatch = 0;
    int checks = 0;
    int w;
    int n_rx = 0;
    int n0;
    int t1 = `READY_TIME_US * 1000;
    logic [7:0] got, tb_tx, host_tx;
    always #4 clk = ~clk;
    // Count received-byte strobes so each access can be held to one byte
    always @(posedge clk) if (rx_valid) n_rx <= n_rx + 1;
    mac_slave i_dut (.clk(clk), .rstn(rstn), .sel_n_in(sel_line), .link_clk(sck),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .req_int(req_int), .sel_drv(sel_drv),
        .sel_drv_oe(sel_drv_oe), .supply_ok(supply_ok), .four_wire(four_wire),
        .power_saving(power_saving), .service_req(service_req), .tx_byte(tx_byte),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .req_done(req_done), .selected(selected),
        .module_en(module_en), .asleep(asleep), .readiness_report_msg_ready(rpt_ready),
        .readiness_report_msg_resume(rpt_resume));
    host_master i_host (.sel_m_n(sel_m_n), .sck(sck), .mosi(mosi),
        .miso(miso_oe ? miso : ~miso), .sel_sense(sel_line));
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task give_verdict;
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Wait for the leading edge of a request, then time its width
    task pulse_len(output int n);
        for (n = 0; n < 400 && !(req_int || sel_drv_oe); n++) @(negedge clk);
        for (n = 0; n < 400 && (req_int || sel_drv_oe); n++) @(negedge clk);
    endtask
    // One master access with random bytes, compared both ways
    task xfer_chk(input int wait_ns);
        tb_tx = 8'($urandom);
        host_tx = 8'($urandom);
        @(posedge clk) tx_byte <= tb_tx;
        n0 = n_rx;
        i_host.xfer(wait_ns, host_tx, got);
        chk(got, tb_tx);
        chk(rx_byte, host_tx);
        chk(8'(n_rx - n0), 8'h01);
    endtask
    // Slave request in either variant, optionally crossed by a master access
    task req_chk(input logic four, input logic simul);
        @(posedge clk) four_wire <= four;
        service_req <= 1'b1;
        @(posedge clk) service_req <= 1'b0;
        fork
            pulse_len(w);
            if (simul) begin
                repeat (10) @(negedge clk);
                xfer_chk(t1);
            end
        join
        chk(8'(w), 8'(`REQ_PULSE_CYC));
        if (!simul) xfer_chk(t1);
    endtask
    initial begin
        void'($urandom(51));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(negedge clk);
        chk(rpt_ready, 8'h02);
        chk(rpt_resume, 8'h0A);
        xfer_chk(t1);
        xfer_chk(t1 + ($urandom % 1000));
        @(posedge clk) power_saving <= 1'b1;
        xfer_chk(`RESUME_TIME_US * 1000);
        chk(8'(asleep), 8'h01);
        @(posedge clk) power_saving <= 1'b0;
        for (int k = 0; k < 6; k++) req_chk(k[0], k == 4);
        // Supply lost: a request and a master access must leave all lines free
        @(posedge clk) supply_ok <= 1'b0;
        repeat (6) @(posedge clk);
        service_req <= 1'b1;
        fork
            i_host.xfer(t1, 8'h5A, got);
            repeat (300) begin
                @(negedge clk);
                chk({5'h00, req_int, sel_drv_oe, miso_oe}, 8'h00);
            end
        join
        @(posedge clk) service_req <= 1'b0;
        supply_ok <= 1'b1;
        give_verdict;
    end
    // Cut a hang short well past the expected run length
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end
endmodule
